/* common/owt_defines.svh */
// Register indices, field positions, reset values and timing counts
`ifndef OWT_DEFINES_SVH
`define OWT_DEFINES_SVH
`define OWT_IDX_CONFIG 16'h0000
`define OWT_IDX_EVT_STAT 16'h0001
`define OWT_IDX_EVT_MASK 16'h0002
`define OWT_IDX_CAUSE 16'h0003
`define OWT_IDX_STATE 16'h0004
`define OWT_IDX_SERVICE 16'hFFFF
`define OWT_CFG_RATE_BIT 0
`define OWT_CFG_DIS_BIT 1
`define OWT_CFG_RESET 2'h0
`define OWT_EVT_SERVICE_BIT 0
`define OWT_EVT_VECCLR_BIT 1
`define OWT_EVT_TIMEOUT_BIT 2
`define OWT_CAUSE_WDG_BIT 0
`define OWT_PRE_W 12
`define OWT_WDG_W 6
`define OWT_TGT_LONG 18'h3FFF0
`define OWT_TGT_SHORT 18'h01FF0
`define OWT_SVC_LOW_KEEP 4
`define OWT_POR_CYCLES 13'h1000
`define OWT_PIN_HOLD 6'h20
`endif

/* common/owt_pkg.sv */
// Types shared by the watchdog design files
package owt_pkg;
   typedef struct packed {
      logic watchdog_disable;
      logic timeout_rate_select;
   } owt_cfg_t;
   typedef struct packed {
      logic timeout;
      logic vector_clear;
      logic service;
   } owt_evt_t;
   typedef struct packed {
      logic hv_on_irq_pin;
      logic hv_on_reset_pin;
      logic monitor_mode;
      logic break_active;
      logic stop_mode;
      logic wait_mode;
   } owt_mode_t;
   typedef enum logic {OWT_PIN_IDLE, OWT_PIN_HOLD} owt_pin_state_t;
endpackage : owt_pkg

/* src/owt_prescaler.sv */
// System integration prescaler: 12-bit counter feeding the watchdog
`timescale 1ns/10ps
`include "owt_defines.svh"
module owt_prescaler (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   input wire logic run,
   input wire logic clr_all,
   input wire logic clr_upper,
   output logic [`OWT_PRE_W-1:0] count,
   output logic wrap
);
   import owt_pkg::*;
   assign wrap = run && (count == {`OWT_PRE_W{1'b1}});
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count <= '0;
      end else if (ce) begin
         if (clr_all) begin
            count <= '0;
         end else if (clr_upper) begin
            // Low stages keep their count (held, not advanced, this cycle) so service timing stays exact
            count <= {{(`OWT_PRE_W-`OWT_SVC_LOW_KEEP){1'b0}},
                      count[`OWT_SVC_LOW_KEEP-1:0]};
         end else if (run) begin
            count <= count + 1'b1;
         end
      end
   end
endmodule : owt_prescaler

/* src/owt_pin_stretch.sv */
// Holds the open-drain reset pin low for a fixed number of cycles
`timescale 1ns/10ps
`include "owt_defines.svh"
module owt_pin_stretch (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   input wire logic start,
   output logic pin_o,
   output logic pin_oe
);
   import owt_pkg::*;
   owt_pin_state_t state;
   logic [5:0] left;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= OWT_PIN_IDLE;
         left <= 6'h00;
         pin_oe <= 1'b0;
      end else if (ce) begin
         case (state)
            OWT_PIN_IDLE: begin
               if (start) begin
                  state <= OWT_PIN_HOLD;
                  left <= `OWT_PIN_HOLD - 6'h01;
                  pin_oe <= 1'b1;
               end
            end
            OWT_PIN_HOLD: begin
               if (left == 6'h00) begin
                  state <= OWT_PIN_IDLE;
                  pin_oe <= 1'b0;
               end else begin
                  left <= left - 6'h01;
               end
            end
            default: begin
               state <= OWT_PIN_IDLE;
               pin_oe <= 1'b0;
            end
         endcase
      end
   end
   // Open drain: only ever drives low
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_o <= 1'b0;
      end else if (ce) begin
         pin_o <= 1'b0;
      end
   end
endmodule : owt_pin_stretch

/* src/owt_top.sv */
// Watchdog timer with prescaler, AHB-Lite registers and reset output
//
// Contract
// - 6-bit watchdog fed by 12-bit prescaler
// - Unserviced overflow requests reset after set period
// - Rate bit one short, zero long
// - Service write clears watchdog, upper prescaler
// - Service read returns vector byte, no service
// - Timeout holds reset pin 32 cycles, flags cause
// - Prescaler cleared 4096 cycles after power-up
// - Internal reset clears both counters
// - Reset vector fetch clears the prescaler
// - Disable bit one stops the watchdog
// - Timeout never raises a processor interrupt
// - Monitor mode high voltage disables watchdog
// - Keeps counting during wait mode
// - Stop freezes clock and clears prescaler
// - Break with reset-pin high voltage disables
// - Counts on the crystal clock directly
// - Rate and disable follow configuration bits
//
// Chosen here: the AHB-Lite register port.
`timescale 1ns/10ps
`include "owt_defines.svh"
module owt_top (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [7:0] reset_vector_lo,
   input wire logic internal_reset,
   input wire logic vector_fetch,
   input wire owt_pkg::owt_mode_t mode,
   output logic wdg_reset_req,
   output logic reset_pin_o,
   output logic reset_pin_oe,
   output logic evt_irq
);
   import owt_pkg::*;

   owt_cfg_t cfg;
   owt_evt_t evt_stat;
   owt_evt_t evt_mask;
   owt_evt_t evt_set;
   logic cause_wdg;
   logic [`OWT_WDG_W-1:0] wdg;
   logic [`OWT_PRE_W-1:0] pre;
   logic pre_wrap;
   logic active;
   logic run;
   logic fire;
   logic svc_wr;
   logic [17:0] target;
   logic [12:0] por_cnt;
   logic por_done;
   logic por_clr;
   logic pre_clr;

   // Bus address phase capture
   logic take;
   logic wr_pend;
   logic [15:0] wr_idx;
   logic [15:0] rd_idx;
   logic [31:0] next_rdata;
   logic wr_hit_cfg;
   logic wr_hit_stat;
   logic wr_hit_mask;
   logic wr_hit_cause;
   logic addr_ok;

   // hsize is not decoded: only whole-word transfers are supported
   assign take = hsel && hready && htrans[1];
   assign rd_idx = haddr[17:2];
   // Anything above the register window is unmapped, writes too
   assign addr_ok = (haddr[31:18] == 14'h0000);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_idx <= 16'h0000;
      end else if (ce) begin
         if (hready) begin
            wr_pend <= take && hwrite && addr_ok;
            wr_idx <= haddr[17:2];
         end
      end
   end

   // Zero wait states, always OKAY
   // Registered so both outputs come straight from flops
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else if (ce) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // Write targets are decoded in the data phase, when hwdata stands
   assign svc_wr = wr_pend && (wr_idx == `OWT_IDX_SERVICE);
   assign wr_hit_cfg = wr_pend && (wr_idx == `OWT_IDX_CONFIG);
   assign wr_hit_stat = wr_pend && (wr_idx == `OWT_IDX_EVT_STAT);
   assign wr_hit_mask = wr_pend && (wr_idx == `OWT_IDX_EVT_MASK);
   assign wr_hit_cause = wr_pend && (wr_idx == `OWT_IDX_CAUSE);

   // Read data prepared in the address phase, shown in the data phase
   always_comb begin
      next_rdata = 32'h0000_0000;
      if (take && !hwrite && addr_ok) begin
         case (rd_idx)
            `OWT_IDX_CONFIG: next_rdata = {30'h0000_0000, cfg};
            `OWT_IDX_EVT_STAT: next_rdata = {29'h0000_0000, evt_stat};
            `OWT_IDX_EVT_MASK: next_rdata = {29'h0000_0000, evt_mask};
            `OWT_IDX_CAUSE: next_rdata = {31'h0000_0000, cause_wdg};
            `OWT_IDX_STATE: begin
               next_rdata = {12'h000, pre, mode.wait_mode, active, wdg};
            end
            // Shared with the vector: reading must not service
            `OWT_IDX_SERVICE: begin
               next_rdata = {24'h00_0000, reset_vector_lo};
            end
            default: next_rdata = 32'h0000_0000;
         endcase
      end
   end

   // Stands for the data phase only, so stale data never lingers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (ce) begin
         if (hready) begin
            hrdata <= next_rdata;
         end
      end
   end

   // Configuration bits drive the counter logic directly
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg <= `OWT_CFG_RESET;
      end else if (ce) begin
         if (wr_hit_cfg) begin
            cfg.timeout_rate_select <= hwdata[`OWT_CFG_RATE_BIT];
            cfg.watchdog_disable <= hwdata[`OWT_CFG_DIS_BIT];
         end
      end
   end

   // Enable: disable bit, monitor and break high-voltage conditions
   always_comb begin
      active = !cfg.watchdog_disable;
      if (mode.monitor_mode &&
          (mode.hv_on_irq_pin || mode.hv_on_reset_pin)) begin
         active = 1'b0;
      end
      if (mode.break_active && mode.hv_on_reset_pin) begin
         active = 1'b0;
      end
   end

   // Wait mode has no effect; besides the enable, only stop gates the count
   assign run = active && !mode.stop_mode;

   // Power-up wait before the first prescaler clear
   // Counter stops once done, so the clear happens only once
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         por_cnt <= 13'h0000;
         por_done <= 1'b0;
      end else if (ce) begin
         if (!por_done) begin
            if (por_cnt == `OWT_POR_CYCLES - 13'h0001) begin
               por_done <= 1'b1;
            end
            por_cnt <= por_cnt + 13'h0001;
         end
      end
   end
   assign por_clr = !por_done &&
                    (por_cnt == `OWT_POR_CYCLES - 13'h0001);

   // Every source that restarts the prescaler from zero
   // A disabled watchdog holds the prescaler at zero as well
   assign pre_clr = internal_reset || fire || por_clr ||
                    vector_fetch ||
                    mode.stop_mode ||
                    !active;

   owt_prescaler u_pre (
      .hclk(hclk),
      .hresetn(hresetn),
      .ce(ce),
      .run(run),
      .clr_all(pre_clr),
      .clr_upper(svc_wr),
      .count(pre),
      .wrap(pre_wrap)
   );

   // Watchdog stage advances on each prescaler wrap
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wdg <= '0;
      end else if (ce) begin
         if (internal_reset || fire || svc_wr || !active) begin
            wdg <= '0;
         end else if (pre_wrap) begin
            wdg <= wdg + 1'b1;
         end
      end
   end

   // Low nibble of the chain is never cleared by service
   // Moving to the short rate mid-count may pass the target: service first
   assign target = cfg.timeout_rate_select ? `OWT_TGT_SHORT :
                   `OWT_TGT_LONG;
   assign fire = run && ({wdg, pre} == target);

   // Single request pulse; pin stretching is done by u_pin below, also started from fire
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wdg_reset_req <= 1'b0;
      end else if (ce) begin
         wdg_reset_req <= fire;
      end
   end

   // Pin hold starts on the same edge as the request flop
   owt_pin_stretch u_pin (
      .hclk(hclk),
      .hresetn(hresetn),
      .ce(ce),
      .start(fire),
      .pin_o(reset_pin_o),
      .pin_oe(reset_pin_oe)
   );

   // Cause flag; a new timeout wins over a clear in the same cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cause_wdg <= 1'b0;
      end else if (ce) begin
         if (fire) begin
            cause_wdg <= 1'b1;
         end else if (wr_hit_cause && hwdata[`OWT_CAUSE_WDG_BIT]) begin
            cause_wdg <= 1'b0;
         end
      end
   end

   // Event status, write one to clear, set wins
   always_comb begin
      evt_set.service = svc_wr;
      evt_set.vector_clear = vector_fetch;
      evt_set.timeout = fire;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         evt_stat <= '0;
      end else if (ce) begin
         if (wr_hit_stat) begin
            evt_stat <= (evt_stat & ~owt_evt_t'(hwdata[2:0])) | evt_set;
         end else begin
            evt_stat <= evt_stat | evt_set;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         evt_mask <= '0;
      end else if (ce) begin
         if (wr_hit_mask) begin
            evt_mask <= owt_evt_t'(hwdata[2:0]);
         end
      end
   end

   // System event line only, not a processor interrupt request
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         evt_irq <= 1'b0;
      end else if (ce) begin
         evt_irq <= |(evt_stat & evt_mask);
      end
   end

endmodule : owt_top

/* tb/owt_top_asserts.sv */
// Port checker for the watchdog top
`timescale 1ns/10ps
module owt_top_asserts (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   input wire logic hresp,
   input wire logic hreadyout,
   input wire logic internal_reset,
   input wire owt_pkg::owt_mode_t mode,
   input wire logic wdg_reset_req,
   input wire logic reset_pin_o,
   input wire logic reset_pin_oe
);
   import owt_pkg::*;
   logic [5:0] run;
   // Frozen cycles (ce low) do not count toward the pin hold
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         run <= 6'h0;
      end else if (!reset_pin_oe) begin
         run <= 6'h0;
      end else if (ce && run != 6'h3F) begin
         run <= run + 6'h1;
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   property p_req_pulse;
      wdg_reset_req && ce |=> !wdg_reset_req;
   endproperty
   a_req_pulse: assert property (p_req_pulse)
      else $error("reset request wider than one cycle");
   property p_req_pin;
      $rose(wdg_reset_req) |-> ##[0:1] reset_pin_oe;
   endproperty
   a_req_pin: assert property (p_req_pin)
      else $error("reset request without pin drive");
   property p_pin_len;
      $fell(reset_pin_oe) |-> run == 6'h20;
   endproperty
   a_pin_len: assert property (p_pin_len)
      else $error("reset pin hold length wrong");
   property p_pin_cause;
      $rose(reset_pin_oe) |-> wdg_reset_req || $past(wdg_reset_req);
   endproperty
   a_pin_cause: assert property (p_pin_cause)
      else $error("reset pin driven without request");
   property p_pin_od;
      !reset_pin_o;
   endproperty
   a_pin_od: assert property (p_pin_od)
      else $error("reset pin data not low");
   property p_okay;
      !hresp && hreadyout;
   endproperty
   a_okay: assert property (p_okay)
      else $error("bus response not okay and ready");
   property p_intreset;
      internal_reset |-> ##2 !wdg_reset_req [*6];
   endproperty
   a_intreset: assert property (p_intreset)
      else $error("timeout right after internal reset");
   property p_mon;
      (mode.monitor_mode && (mode.hv_on_irq_pin || mode.hv_on_reset_pin))
         [*3] |-> !wdg_reset_req;
   endproperty
   a_mon: assert property (p_mon)
      else $error("timeout in monitor mode with high voltage");
   property p_brk;
      (mode.break_active && mode.hv_on_reset_pin) [*3] |-> !wdg_reset_req;
   endproperty
   a_brk: assert property (p_brk)
      else $error("timeout in break with high voltage");
endmodule : owt_top_asserts

bind owt_top owt_top_asserts owt_top_asserts_i (
   .hclk(hclk),
   .hresetn(hresetn),
   .ce(ce),
   .hresp(hresp),
   .hreadyout(hreadyout),
   .internal_reset(internal_reset),
   .mode(mode),
   .wdg_reset_req(wdg_reset_req),
   .reset_pin_o(reset_pin_o),
   .reset_pin_oe(reset_pin_oe)
);

/* tb/tb_operating_watchdog_timer.sv */
// Self-checking bench for the watchdog top
`timescale 1ns/10ps
`include "owt_defines.svh"
module tb_operating_watchdog_timer;
   import owt_pkg::*;
   localparam int LIM = 8300;
   localparam int LO = 8173;
   localparam int HI = 8180;
   logic hclk = 1'h0;
   logic hresetn = 1'h0;
   logic ce = 1'h1;
   logic hsel = 1'h0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'h0;
   logic [31:0] hwdata = 32'h0;
   logic internal_reset = 1'h0;
   logic vector_fetch = 1'h0;
   owt_mode_t mode = '0;
   logic [31:0] hrdata;
   logic hreadyout, hresp, wdg_reset_req, reset_pin_o, reset_pin_oe, evt_irq;
   int n_fail = 0;
   int n_tests = 0;
   int n;
   logic [31:0] d;
   logic [31:0] d0;
   logic [79:0] rows [6] = '{
      {`OWT_IDX_CONFIG, 32'h3, 32'h3},
      {`OWT_IDX_CONFIG, 32'hFFFFFFFC, 32'h0},
      {`OWT_IDX_EVT_MASK, 32'hFF, 32'h7},
      {`OWT_IDX_EVT_MASK, 32'h0, 32'h0},
      {16'h0005, 32'hFFFFFFFF, 32'h0},
      {`OWT_IDX_SERVICE, 32'h12345678, 32'hA5}};
   // Config, mode bits, fire expected
   logic [8:0] mrow [8] = '{
      {2'h1, 6'h01, 1'h1},
      {2'h1, 6'h28, 1'h0},
      {2'h1, 6'h18, 1'h0},
      {2'h1, 6'h14, 1'h0},
      {2'h1, 6'h02, 1'h0},
      {2'h3, 6'h00, 1'h0},
      {2'h0, 6'h00, 1'h0},
      {2'h1, 6'h24, 1'h1}};
   always #12.5 hclk = ~hclk;
   owt_top owt_top_i (
      .hclk(hclk),
      .hresetn(hresetn),
      .ce(ce),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(3'h2),
      .hwdata(hwdata),
      .hready(hreadyout),
      .hrdata(hrdata),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .reset_vector_lo(8'hA5),
      .internal_reset(internal_reset),
      .vector_fetch(vector_fetch),
      .mode(mode),
      .wdg_reset_req(wdg_reset_req),
      .reset_pin_o(reset_pin_o),
      .reset_pin_oe(reset_pin_oe),
      .evt_irq(evt_irq)
   );
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         $display("[FAIL] %s exp %h got %h", nm, e, g);
         n_fail++;
      end
   endtask : chk
   // Byte address is four times the register index
   task automatic xfer(input logic [15:0] idx, input logic wr,
                       input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'h1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {14'h0, idx, 2'h0};
      @(posedge hclk);
      while (hreadyout !== 1'h1) @(posedge hclk);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'h1) @(posedge hclk);
      rd = hrdata;
   endtask : xfer
   task automatic ir();
      internal_reset <= 1'h1;
      @(posedge hclk);
      internal_reset <= 1'h0;
   endtask : ir
   task automatic wait_req(input int lim);
      n = 0;
      while (n < lim && wdg_reset_req !== 1'h1) begin
         @(posedge hclk);
         #1;
         n++;
      end
      // Back onto the edge so later stimulus stays edge-aligned
      @(posedge hclk);
   endtask : wait_req
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : stop_test
   initial begin
      #2450000;
      n_fail++;
      stop_test();
   end
   initial begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'h1;
      @(posedge hclk);
      xfer(`OWT_IDX_CONFIG, 1'h0, 32'h0, d);
      chk("cfg_reset", 32'h0, d);
      xfer(`OWT_IDX_CAUSE, 1'h0, 32'h0, d);
      chk("cause_reset", 32'h0, d);
      foreach (rows[i]) begin
         xfer(rows[i][79:64], 1'h1, rows[i][63:32], d);
         xfer(rows[i][79:64], 1'h0, 32'h0, d);
         chk("reg", rows[i][31:0], d);
      end
      // Power-up clear must have landed before timing the periods
      repeat (4100) @(posedge hclk);
      xfer(`OWT_IDX_STATE, 1'h0, 32'h0, d);
      d = {31'h0, d[19:8] < 12'h040 && d[5:0] == 6'h00};
      chk("por_clear", 32'h1, d);
      foreach (mrow[i]) begin
         xfer(`OWT_IDX_CONFIG, 1'h1, {30'h0, mrow[i][8:7]}, d);
         mode <= owt_mode_t'(mrow[i][6:1]);
         ir();
         wait_req(LIM);
         d = {31'h0, n >= LO && n <= HI};
         chk("timeout", {31'h0, mrow[i][0]}, d);
      end
      mode <= '0;
      // A read of the service place must leave the count running
      ir();
      repeat (4000) @(posedge hclk);
      xfer(`OWT_IDX_SERVICE, 1'h0, 32'h0, d);
      wait_req(LIM);
      chk("svc_read", 32'h1, {31'h0, n < 4400});
      ir();
      repeat (4000) @(posedge hclk);
      xfer(`OWT_IDX_SERVICE, 1'h1, 32'h0, d);
      wait_req(8000);
      chk("svc_write", 32'd8000, n);
      xfer(`OWT_IDX_CAUSE, 1'h0, 32'h0, d);
      chk("cause", 32'h1, d);
      xfer(`OWT_IDX_CAUSE, 1'h1, 32'h1, d);
      xfer(`OWT_IDX_CAUSE, 1'h0, 32'h0, d);
      chk("cause_clr", 32'h0, d);
      xfer(`OWT_IDX_EVT_STAT, 1'h0, 32'h0, d);
      chk("events", 32'h5, d);
      chk("irq_masked", 32'h0, {31'h0, evt_irq});
      xfer(`OWT_IDX_EVT_MASK, 1'h1, 32'h4, d);
      repeat (4) @(posedge hclk);
      chk("irq_on", 32'h1, {31'h0, evt_irq});
      xfer(`OWT_IDX_EVT_STAT, 1'h1, 32'h7, d);
      repeat (4) @(posedge hclk);
      chk("irq_clr", 32'h0, {31'h0, evt_irq});
      vector_fetch <= 1'h1;
      @(posedge hclk);
      vector_fetch <= 1'h0;
      xfer(`OWT_IDX_EVT_STAT, 1'h0, 32'h0, d);
      chk("vec_fetch", 32'h2, d);
      chk("irq_vec", 32'h0, {31'h0, evt_irq});
      // Frozen cycles must not advance the prescaler
      xfer(`OWT_IDX_STATE, 1'h0, 32'h0, d0);
      ce <= 1'h0;
      repeat (50) @(posedge hclk);
      ce <= 1'h1;
      xfer(`OWT_IDX_STATE, 1'h0, 32'h0, d);
      chk("ce_freeze", 32'h2, {20'h0, d[19:8] - d0[19:8]});
      // Mid-run reset returns configuration and cause flag to zero
      xfer(`OWT_IDX_CONFIG, 1'h1, 32'h3, d);
      hresetn <= 1'h0;
      @(posedge hclk);
      chk("pin_rst", 32'h0, {31'h0, reset_pin_oe});
      chk("req_rst", 32'h0, {31'h0, wdg_reset_req});
      @(posedge hclk);
      hresetn <= 1'h1;
      @(posedge hclk);
      xfer(`OWT_IDX_CONFIG, 1'h0, 32'h0, d);
      chk("cfg_rst", 32'h0, d);
      xfer(`OWT_IDX_CAUSE, 1'h0, 32'h0, d);
      chk("cause_rst", 32'h0, d);
      stop_test();
   end
endmodule : tb_operating_watchdog_timer
